/* File: shared/t2rc_pkg.sv */
// Purpose: Shared constants for the second timer with reload, clock-out and baud modes.
// Assumes: 32-bit AHB-Lite data, one aligned word per register.
// Notes:   Byte address of each register is four times its index.
package t2rc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int unsigned AW = 12;      // Bus address width.
    localparam logic [9:0] IDX_CTRL = 10'h0C8; // Control register index.
    localparam logic [9:0] IDX_MODE = 10'h0C9; // Mode register index.
    localparam logic [9:0] IDX_CLO  = 10'h0CA; // Counter low byte index.
    localparam logic [9:0] IDX_CHI  = 10'h0CB; // Counter high byte index.
    localparam logic [9:0] IDX_RLO  = 10'h0CC; // Reload low byte index.
    localparam logic [9:0] IDX_RHI  = 10'h0CD; // Reload high byte index.
    localparam logic [AW-1:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [AW-1:0] ADDR_MODE = {IDX_MODE, 2'b00};
    localparam logic [AW-1:0] ADDR_CLO  = {IDX_CLO, 2'b00};
    localparam logic [AW-1:0] ADDR_CHI  = {IDX_CHI, 2'b00};
    localparam logic [AW-1:0] ADDR_RLO  = {IDX_RLO, 2'b00};
    localparam logic [AW-1:0] ADDR_RHI  = {IDX_RHI, 2'b00};

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned B_OVF  = 7;   // Overflow flag.
    localparam int unsigned B_EXT  = 6;   // External flag.
    localparam int unsigned B_RXS  = 5;   // Receive clock select.
    localparam int unsigned B_TXS  = 4;   // Transmit clock select.
    localparam int unsigned B_EXEN = 3;   // External enable.
    localparam int unsigned B_RUN  = 2;   // Run bit.
    localparam int unsigned B_TCS  = 1;   // Timer/counter select.
    localparam int unsigned B_IRQE = 2;   // Mode: interrupt enable.
    localparam int unsigned B_COE  = 1;   // Mode: clock-out enable.
    localparam int unsigned B_DOWN_COUNT_ENABLE = 0;   // Mode: down-count enable.

    // ************************************************************
    // Reset values and counts
    // ************************************************************
    localparam logic [7:0]  CTRL_RST = 8'h00;  // Control after reset.
    localparam logic [7:0]  MODE_RST = 8'h00;  // Mode after reset, counts up.
    localparam logic [15:0] CNT_RST  = 16'h0000;
    localparam logic [15:0] CNT_MAX  = 16'hFFFF; // Top of count.
    localparam int unsigned MC_CLKS  = 6;   // Clocks per machine cycle.
    localparam int unsigned BAUD_DIV = 16;  // Overflows per baud tick.

endpackage

/* File: src/t2rc_prescale.sv */
// Purpose: Machine-cycle enable divider.
// Assumes: One clock domain.
// Notes:   Pulse is one clock wide, once every DIV clocks.
`timescale 1ns/10ps
module t2rc_prescale
    import t2rc_pkg::*;
#(
    parameter int unsigned DIV = MC_CLKS
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    output logic      tick
);

    // Divider count, wraps at DIV-1.
    logic [3:0] cnt_reg;
    logic       wrap;

    assign wrap = (cnt_reg == 4'(DIV - 1));

    // Count clocks and emit one pulse per wrap.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg <= 4'h0;
            tick    <= 1'b0;
        end else begin
            cnt_reg <= wrap ? 4'h0 : cnt_reg + 4'h1;
            tick    <= wrap;
        end
    end

endmodule

/* File: src/t2rc_edge.sv */
// Purpose: Falling-edge detector sampled once per machine cycle.
// Assumes: Pin is synchronous to hclk.
// Notes:   High sample, then low sample, then pulse in the third cycle.
`timescale 1ns/10ps
module t2rc_edge (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic sample_en,
    input  wire logic pin,
    output logic      fall
);

    // Current and previous machine-cycle samples.
    logic       now_reg;
    logic       prev_reg;
    logic [1:0] seen_reg; // Marks the first two real samples after reset.

    // No edge is reported until two real samples exist, so a pin held low
    // through reset gives no false edge, whatever its idle level.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            now_reg  <= 1'b1;
            prev_reg <= 1'b1;
            seen_reg <= 2'h0;
            fall     <= 1'b0;
        end else begin
            fall <= 1'b0;
            if (sample_en) begin
                now_reg  <= pin;
                prev_reg <= now_reg;
                seen_reg <= {seen_reg[0], 1'b1};
                fall     <= seen_reg[1] & prev_reg & ~now_reg;
            end
        end
    end

endmodule

/* File: src/t2rc_timer.sv */
// Purpose: Second 16-bit timer: auto-reload up/down, clock-out, baud generator.
// Assumes: AHB-Lite slave, zero wait states, word transfers only.
// Notes:   Capture mode and serial framing are not part of this block.
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module t2rc_timer
    import t2rc_pkg::*;
(
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [AW-1:0] haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic      [31:0]   hrdata,
    output logic               hreadyout,
    output logic               hresp,
    input  wire logic          trigger_pin,
    input  wire logic          count_clock_pin_in,
    output logic               count_clock_pin_out,
    output logic               count_clock_pin_oe,
    input  wire logic          timer1_ovf,
    output logic               tx_baud_tick,
    output logic               rx_baud_tick,
    output logic               timer_irq
);

    // ************************************************************
    // Bus slave
    // ************************************************************
    logic [7:0]    ctrl_reg;   // Timer control register.
    logic [7:0]    mode_reg;   // Timer mode register.
    logic [15:0]   cnt_reg;    // Counter high and low bytes.
    logic [15:0]   rld_reg;    // Reload high and low bytes.
    logic          dph_wr_reg; // Write pending in data phase.
    logic [AW-1:0] dph_adr_reg;
    logic          aph_take;
    logic [31:0]   rd_val;
    logic [7:0]    wbyte;

    // Only NONSEQ/SEQ selected transfers are taken; size is always a word.
    assign aph_take = hsel & htrans[1] & hready;
    assign wbyte    = hwdata[7:0];

    // Read mux, unmapped addresses read as zero.
    assign rd_val = (haddr == ADDR_CTRL) ? {24'h0, ctrl_reg[7:1], 1'b0} :
                    (haddr == ADDR_MODE) ? {24'h0, 5'h00, mode_reg[2:0]} :
                    (haddr == ADDR_CLO)  ? {24'h0, cnt_reg[7:0]} :
                    (haddr == ADDR_CHI)  ? {24'h0, cnt_reg[15:8]} :
                    (haddr == ADDR_RLO)  ? {24'h0, rld_reg[7:0]} :
                    (haddr == ADDR_RHI)  ? {24'h0, rld_reg[15:8]} : 32'h0000_0000;

    // Address phase capture; read data is ready for the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr_reg  <= 1'b0;
            dph_adr_reg <= '0;
            hrdata      <= 32'h0000_0000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            dph_wr_reg <= aph_take & hwrite;
            // Read data is fetched at the address edge, so reads never wait.
            if (aph_take) begin
                dph_adr_reg <= haddr;
                hrdata      <= hwrite ? 32'h0000_0000 : rd_val;
            end
        end
    end

    // Write strobes, one per register, valid in the data phase.
    logic wr_ctrl, wr_mode, wr_clo, wr_chi, wr_rlo, wr_rhi;
    assign wr_ctrl = dph_wr_reg & (dph_adr_reg == ADDR_CTRL);
    assign wr_mode = dph_wr_reg & (dph_adr_reg == ADDR_MODE);
    assign wr_clo  = dph_wr_reg & (dph_adr_reg == ADDR_CLO);
    assign wr_chi  = dph_wr_reg & (dph_adr_reg == ADDR_CHI);
    assign wr_rlo  = dph_wr_reg & (dph_adr_reg == ADDR_RLO);
    assign wr_rhi  = dph_wr_reg & (dph_adr_reg == ADDR_RHI);

    // ************************************************************
    // Mode decode
    // ************************************************************
    logic run, tcs, exen, txs, rxs, down_count_enable, coe, irqe;
    logic baud, clkout, updown, down;
    // Each mode bit is tapped straight from its register.
    assign run  = ctrl_reg[B_RUN];
    assign tcs  = ctrl_reg[B_TCS];
    assign exen = ctrl_reg[B_EXEN];
    assign txs  = ctrl_reg[B_TXS];
    assign rxs  = ctrl_reg[B_RXS];
    assign down_count_enable = mode_reg[B_DOWN_COUNT_ENABLE];
    assign coe  = mode_reg[B_COE];
    assign irqe = mode_reg[B_IRQE];

    // Baud mode wins over clock-out, which needs timer select.
    assign baud   = txs | rxs;
    assign clkout = ~baud & coe & ~tcs;
    assign updown = ~baud & ~clkout & down_count_enable;
    assign down   = updown & ~trigger_pin;

    // ************************************************************
    // Count enables
    // ************************************************************
    logic mc_en;     // Machine-cycle enable.
    logic trig_fall; // Falling edge on the trigger pin.
    logic pin_fall;  // Falling edge on the count clock pin.
    logic tick;

    t2rc_prescale #(.DIV(MC_CLKS)) u_pre (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick    (mc_en)
    );

    t2rc_edge u_trig (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .sample_en (mc_en),
        .pin       (trigger_pin),
        .fall      (trig_fall)
    );

    // Counter select counts falls of the count pin, sampled like the trigger.
    t2rc_edge u_cnt (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .sample_en (mc_en),
        .pin       (count_clock_pin_in),
        .fall      (pin_fall)
    );

    // With timer select, baud and clock-out timers run at the oscillator, others per machine cycle.
    assign tick = run & (tcs ? pin_fall : ((baud | clkout) ? 1'b1 : mc_en));

    // ************************************************************
    // Counter events
    // ************************************************************
    // One-cycle events from the tick, the pin edges and the mode.
    logic roll, unf, ext_rld, ovf_set, ext_set, ext_tog;
    assign roll    = tick & ~down & (cnt_reg == CNT_MAX);
    assign unf     = tick & down & (cnt_reg == rld_reg);
    assign ext_rld = run & exen & trig_fall & ~baud & ~updown & ~clkout;
    assign ovf_set = (roll | unf) & ~baud & ~clkout;
    assign ext_set = exen & trig_fall & ~updown;
    assign ext_tog = updown & (roll | unf);

    // Counter next value; a bus write to a byte wins over counting.
    logic [15:0] cnt_next;
    always_comb begin
        cnt_next = cnt_reg;
        if (unf) begin
            cnt_next = CNT_MAX;
        end else if (roll | ext_rld) begin
            cnt_next = rld_reg;
        end else if (tick) begin
            cnt_next = down ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;
        end
        // Byte writes land last, so a count in the same cycle never overrides what software wrote.
        if (wr_clo) begin
            cnt_next[7:0] = wbyte;
        end
        if (wr_chi) begin
            cnt_next[15:8] = wbyte;
        end
    end

    // Flag next values: a hardware set wins over a software clear.
    logic [7:0] ctrl_next;
    always_comb begin
        // Bit 0 has no function in this block and always stays zero.
        ctrl_next = wr_ctrl ? {wbyte[7:1], 1'b0} : ctrl_reg;
        ctrl_next[B_OVF] = ctrl_next[B_OVF] | ovf_set;
        ctrl_next[B_EXT] = (ctrl_next[B_EXT] ^ ext_tog) | ext_set;
    end

    // Register state; reload bytes are plain storage.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= CTRL_RST;
            mode_reg <= MODE_RST;
            cnt_reg  <= CNT_RST;
            rld_reg  <= CNT_RST;
        end else begin
            ctrl_reg <= ctrl_next;
            cnt_reg  <= cnt_next;
            // Only the three defined mode bits are stored; the rest read zero.
            if (wr_mode) begin
                mode_reg <= {5'h00, wbyte[2:0]};
            end
            if (wr_rlo) begin
                rld_reg[7:0] <= wbyte;
            end
            if (wr_rhi) begin
                rld_reg[15:8] <= wbyte;
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    logic [3:0] tx_div_reg; // Divide-by-16 of transmit overflows.
    logic [3:0] rx_div_reg; // Divide-by-16 of receive overflows.
    logic       tx_ovf, rx_ovf;

    // Each direction takes this timer's rollover or the other timer's.
    assign tx_ovf = txs ? roll : timer1_ovf;
    assign rx_ovf = rxs ? roll : timer1_ovf;

    // Registered outputs; the pin toggles once per clock-out rollover.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_div_reg          <= 4'h0;
            rx_div_reg          <= 4'h0;
            tx_baud_tick        <= 1'b0;
            rx_baud_tick        <= 1'b0;
            count_clock_pin_out <= 1'b0;
            count_clock_pin_oe  <= 1'b0;
            timer_irq           <= 1'b0;
        end else begin
            tx_div_reg   <= tx_ovf ? tx_div_reg + 4'h1 : tx_div_reg;
            rx_div_reg   <= rx_ovf ? rx_div_reg + 4'h1 : rx_div_reg;
            tx_baud_tick <= tx_ovf & (tx_div_reg == 4'(BAUD_DIV - 1));
            rx_baud_tick <= rx_ovf & (rx_div_reg == 4'(BAUD_DIV - 1));
            if (clkout & roll) begin
                count_clock_pin_out <= ~count_clock_pin_out;
            end
            // The enable follows the mode, so the pin is released when it ends.
            count_clock_pin_oe <= clkout;
            // Level request; it drops one clock after both flags are cleared.
            timer_irq <= irqe & (ctrl_reg[B_OVF] | ctrl_reg[B_EXT]);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Counter checks skip cycles with a byte write, since the write wins.
    up_reload_a: assert property (roll & ~wr_clo & ~wr_chi |=> cnt_reg == $past(rld_reg))
        else $error("rollover did not reload counter");
    down_load_a: assert property (unf & ~wr_clo & ~wr_chi |=> cnt_reg == CNT_MAX)
        else $error("underflow did not load top");
    ovf_flag_a: assert property (ovf_set |=> ctrl_reg[B_OVF])
        else $error("overflow flag not set");
    flag_cause_a: assert property ($rose(ctrl_reg[B_OVF])
                                   |-> $past(~baud & ~clkout | wr_ctrl))
        else $error("overflow flag set in baud or clock-out mode");
    irq_out_a: assert property (irqe & ctrl_reg[B_EXT] |=> timer_irq)
        else $error("interrupt not raised");
    ext_tog_a: assert property (ext_tog & ~wr_ctrl
                                |=> ctrl_reg[B_EXT] != $past(ctrl_reg[B_EXT]))
        else $error("external flag did not toggle");
    ext_edge_a: assert property (ext_set |=> ctrl_reg[B_EXT])
        else $error("edge did not set external flag");
    baud_norld_a: assert property (baud |-> ~ext_rld)
        else $error("edge reloaded in baud mode");
    up_step_a: assert property (tick & ~down & ~roll & ~ext_rld & ~wr_clo & ~wr_chi
                                |=> cnt_reg == $past(cnt_reg) + 16'h0001)
        else $error("counter did not step up");
    pin_tog_a: assert property (clkout & roll
                                |=> count_clock_pin_out != $past(count_clock_pin_out))
        else $error("clock-out pin did not toggle");
    down_step_a: assert property (tick & down & ~unf & ~wr_clo & ~wr_chi
                                  |=> cnt_reg == $past(cnt_reg) - 16'h0001)
        else $error("counter did not step down");
    irq_off_a: assert property (~irqe |=> ~timer_irq)
        else $error("interrupt raised while disabled");
    pin_enable_a: assert property (clkout |=> count_clock_pin_oe)
        else $error("clock-out pin not driven");
    baud_flag_a: assert property (baud & ~wr_ctrl
                                  |=> ctrl_reg[B_OVF] == $past(ctrl_reg[B_OVF]))
        else $error("overflow flag changed in baud mode");
    tx_tick_a: assert property (tx_baud_tick |-> $past(tx_ovf))
        else $error("transmit tick without overflow");

    roll_c: cover property (roll & ~baud);
    unf_c: cover property (unf);
    baud_c: cover property (baud & tx_baud_tick);
    clkout_c: cover property (clkout & roll);
    ext_tog_c: cover property (ext_tog);

endmodule

/* File: tb/t2rc_far.sv */
// Purpose: Far-side model: other timer overflow, trigger and count pins.
// Assumes: Pins change only just after a rising clock edge.
// Notes:   Gaps are clocks between successive pulses of each output.
`timescale 1ns/10ps
module t2rc_far
    import t2rc_pkg::*;
#(
    parameter int unsigned T1_GAP = 5
) (
    input  wire logic hclk,
    input  wire logic tx_baud_tick,
    input  wire logic rx_baud_tick,
    input  wire logic clk_out,
    output logic      timer1_ovf,
    output logic      trigger_pin,
    output logic      cnt_drive
);
    // ************************************************************
    // Timing records
    // ************************************************************
    int   t1_cnt = 0;   // Clocks into the other timer's period.
    int   tx_cnt = 0;   // Clocks since the last transmit tick.
    int   rx_cnt = 0;   // Clocks since the last receive tick.
    int   co_cnt = 0;   // Clocks since the last clock-out rise.
    int   tx_gap = 0;   // Last transmit tick spacing.
    int   rx_gap = 0;   // Last receive tick spacing.
    int   co_gap = 0;   // Last clock-out period.
    logic co_last = 0;  // Previous clock-out level.

    // Pins idle with the trigger high so a first fall is a real edge.
    initial begin
        timer1_ovf = 1'b0;
        trigger_pin = 1'b1;
        cnt_drive = 1'b0;
    end

    // The other timer overflows once per T1_GAP clocks; spacings are logged.
    always @(posedge hclk) begin
        t1_cnt <= (t1_cnt + 1) % T1_GAP;
        timer1_ovf <= (t1_cnt == T1_GAP - 1);
        co_last <= clk_out;
        tx_cnt <= tx_baud_tick ? 1 : tx_cnt + 1;
        rx_cnt <= rx_baud_tick ? 1 : rx_cnt + 1;
        co_cnt <= (clk_out && !co_last) ? 1 : co_cnt + 1;
        if (tx_baud_tick) begin
            tx_gap <= tx_cnt;
        end
        if (rx_baud_tick) begin
            rx_gap <= rx_cnt;
        end
        if (clk_out && !co_last) begin
            co_gap <= co_cnt;
        end
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    task automatic hold(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // Each level stands three machine cycles, so edges are well spaced.
    task automatic trig_set(input logic lvl);
        trigger_pin <= lvl;
        hold(3 * MC_CLKS);
    endtask

    // A high, low, high sequence gives the sampler one clean fall.
    task automatic trig_fall();
        trig_set(1'b1);
        trig_set(1'b0);
        trig_set(1'b1);
    endtask

    // Each pulse gives exactly one falling edge on the count pin.
    task automatic pulse(input int n);
        repeat (n) begin
            cnt_drive <= 1'b1;
            hold(3 * MC_CLKS);
            cnt_drive <= 1'b0;
            hold(3 * MC_CLKS);
        end
    endtask
endmodule

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the second timer over AHB-Lite.
// Assumes: Zero-wait slave; far side modelled by t2rc_far.
// Notes:   Counter mode makes counts exact; rates are read as gaps.
`timescale 1ns/10ps
module testbench;
    import t2rc_pkg::*;
    logic          hclk;        // Bus clock.
    logic          hresetn;     // Active-low reset.
    logic          hsel;        // Slave select.
    logic          hwrite;      // Write strobe.
    logic [AW-1:0] haddr;       // Byte address.
    logic [1:0]    htrans;      // Transfer type.
    logic [2:0]    hsize;       // Transfer size, always a word.
    logic [31:0]   hwdata;      // Write data.
    logic [31:0]   hrdata;      // Read data.
    logic [31:0]   rdat;        // Last data taken.
    logic          hreadyout;   // Slave ready.
    logic          hresp;       // Slave response.
    logic          trig;        // Trigger pin level.
    logic          far_cnt;     // Far-side count drive.
    logic          cco;         // Clock-out level.
    logic          coe;         // Clock-out enable.
    logic          t1_ovf;      // Other timer overflow.
    logic          txt;         // Transmit tick.
    logic          rxt;         // Receive tick.
    logic          irq;         // Timer interrupt.
    wire logic     cpin;        // Resolved count pin.
    int            miscompares; // Mismatches seen.
    int            comparisons; // Compares made.
    logic [7:0]    cfg_list [2] = '{8'h14, 8'h24}; // Transmit only, then receive only.

    // The pin carries the design's clock while it drives, else the far side.
    assign cpin = coe ? cco : far_cnt;

    t2rc_timer u_t2rc_timer (
        .hclk                (hclk),
        .hresetn             (hresetn),
        .hsel                (hsel),
        .haddr               (haddr),
        .htrans              (htrans),
        .hwrite              (hwrite),
        .hsize               (hsize),
        .hwdata              (hwdata),
        .hready              (hreadyout),
        .hrdata              (hrdata),
        .hreadyout           (hreadyout),
        .hresp               (hresp),
        .trigger_pin         (trig),
        .count_clock_pin_in  (cpin),
        .count_clock_pin_out (cco),
        .count_clock_pin_oe  (coe),
        .timer1_ovf          (t1_ovf),
        .tx_baud_tick        (txt),
        .rx_baud_tick        (rxt),
        .timer_irq           (irq)
    );

    t2rc_far u_t2rc_far (
        .hclk         (hclk),
        .tx_baud_tick (txt),
        .rx_baud_tick (rxt),
        .clk_out      (cco),
        .timer1_ovf   (t1_ovf),
        .trigger_pin  (trig),
        .cnt_drive    (far_cnt)
    );

    // ************************************************************
    // Bus and check tasks
    // ************************************************************
    task automatic end_sim();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t ns: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    // Waits for ready at a rising edge; a hang ends the run.
    task automatic rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) begin
            miscompares++;
            $display("[ERR] %0t ns: bus hang", $time);
            end_sim();
        end
    endtask

    // One single transfer: address phase, then data phase.
    task automatic bus(input logic w, input logic [AW-1:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'h2;
        rdy();
        htrans <= 2'b00;
        hwdata <= {24'h000000, d};
        rdy();
        rdat = hrdata;
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rchk(input logic [AW-1:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(rdat, {24'h000000, e});
    endtask

    // Low byte first; the high byte sits one word above.
    task automatic w16(input logic [AW-1:0] lo, input logic [15:0] v);
        wr(lo, v[7:0]);
        wr(lo + 12'h004, v[15:8]);
    endtask

    // ************************************************************
    // Clock, watchdog and scenarios
    // ************************************************************
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    initial begin
        repeat (100000) @(posedge hclk);
        miscompares++;
        $display("[ERR] %0t ns: run too long", $time);
        end_sim();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        miscompares = 0;
        comparisons = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(ADDR_MODE, 8'h00);
        rchk(ADDR_CTRL, 8'h00);
        rchk(12'h000, 8'h00);
        chk(hresp, 32'h0);
        wr(ADDR_MODE, 8'hFF);
        rchk(ADDR_MODE, 8'h07);
        // Counter mode: three falls from FFFD must wrap exactly once.
        wr(ADDR_MODE, 8'h04);
        w16(ADDR_RLO, 16'hFFFD);
        w16(ADDR_CLO, 16'hFFFD);
        wr(ADDR_CTRL, 8'h06);
        u_t2rc_far.pulse(2);
        rchk(ADDR_CTRL, 8'h06);
        rchk(ADDR_CLO, 8'hFF);
        u_t2rc_far.pulse(1);
        rchk(ADDR_CTRL, 8'h86);
        chk(irq, 32'h1);
        rchk(ADDR_CLO, 8'hFD);
        rchk(ADDR_CHI, 8'hFF);
        wr(ADDR_CTRL, 8'h06);
        repeat (2) @(posedge hclk);
        chk(irq, 32'h0);
        // A trigger fall reloads an idle count and flags it.
        wr(ADDR_MODE, 8'h00);
        w16(ADDR_RLO, 16'h1234);
        w16(ADDR_CLO, 16'h0000);
        wr(ADDR_CTRL, 8'h0E);
        u_t2rc_far.trig_fall();
        rchk(ADDR_CTRL, 8'h4E);
        rchk(ADDR_CLO, 8'h34);
        rchk(ADDR_CHI, 8'h12);
        // Up/down: one wrap each way, the external flag toggling.
        wr(ADDR_CTRL, 8'h06);
        wr(ADDR_MODE, 8'h01);
        w16(ADDR_RLO, 16'h0050);
        w16(ADDR_CLO, 16'hFFFF);
        u_t2rc_far.pulse(1);
        rchk(ADDR_CTRL, 8'hC6);
        rchk(ADDR_CLO, 8'h50);
        u_t2rc_far.trig_set(1'b0);
        wr(ADDR_CTRL, 8'h06);
        w16(ADDR_CLO, 16'h0051);
        u_t2rc_far.pulse(3);
        rchk(ADDR_CTRL, 8'hC6);
        rchk(ADDR_CHI, 8'hFF);
        u_t2rc_far.trig_set(1'b1);
        // Clock-out: reload FFF0 gives a 32-clock period and no flag.
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_MODE, 8'h06);
        w16(ADDR_RLO, 16'hFFF0);
        w16(ADDR_CLO, 16'hFFF0);
        wr(ADDR_CTRL, 8'h04);
        repeat (200) @(posedge hclk);
        chk(u_t2rc_far.co_gap, 32'h20);
        chk(coe, 32'h1);
        rchk(ADDR_CTRL, 8'h04);
        chk(irq, 32'h0);
        // Baud: the own side ticks every 16 x 2 clocks, the other every 80.
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_MODE, 8'h04);
        w16(ADDR_RLO, 16'hFFFE);
        w16(ADDR_CLO, 16'hFFFE);
        foreach (cfg_list[i]) begin
            wr(ADDR_CTRL, cfg_list[i]);
            repeat (300) @(posedge hclk);
            chk(u_t2rc_far.tx_gap, cfg_list[i][4] ? 32'h20 : 32'h50);
            chk(u_t2rc_far.rx_gap, cfg_list[i][5] ? 32'h20 : 32'h50);
            rchk(ADDR_CTRL, cfg_list[i]);
            chk(irq, 32'h0);
        end
        chk(coe, 32'h0);
        wr(ADDR_CTRL, 8'h1C);
        u_t2rc_far.trig_fall();
        rchk(ADDR_CTRL, 8'h5C);
        chk(irq, 32'h1);
        end_sim();
    end

endmodule
